// >>> rtl/tecp_pkg.sv
// Constants and types for the timer/event counter with source selection
// ============================================================
// How it works
// - Source field 00 picks clock/256, 01 event pin, 10 clock/32, 11 clock/4.
// - Count is an 8-bit binary up-counter, one step per count pulse.
// - Count goes to zero on start instruction, reset, or wrap from FF.
// - Start instruction zeroes the count and starts timing; counting then continues.
// - With event source, count advances on each rising edge of the event pin.
// - The 256th pulse wraps count, pulses overflow event, sets request flag.
// - After overflow the counter keeps counting from zero, free-running.
// - Skip-on-request or start instruction clears the timer request flag.
// - Read-count instruction returns the count at any time without disturbing it.
// - Count pulses are held off during read-count so reads are never torn.
// - CPU clock is the system clock divided by two.
// - Halt gates only the divide-by-two input; prescalers keep running.
// - A timer overflow ends halt mode.
// - Source selection stays active during halt, still feeding pulses.
package tecp_pkg;
  // ============================================================
  // Source select encodings
  localparam logic [1:0] SRC_DIV256 = 2'h0;
  localparam logic [1:0] SRC_EVENT  = 2'h1;
  localparam logic [1:0] SRC_DIV32  = 2'h2;
  localparam logic [1:0] SRC_DIV4   = 2'h3;
  localparam logic [1:0] SRC_RESET  = 2'h0;
  // Nibble field positions of the mode write
  localparam int SEL_LOW_BIT  = 1;
  localparam int SEL_HIGH_BIT = 2;
  // Prescaler taps: divide by 4, 32, 256
  localparam int TAP_DIV4   = 1;
  localparam int TAP_DIV32  = 4;
  localparam int TAP_DIV256 = 7;
  localparam int PRESC_W    = 8;
  localparam int COUNT_W    = 8;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 8'hFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 8'h01;
  localparam logic [PRESC_W-1:0] PRESC_ONE  = 8'h01;

  // CPU instruction strobes, one cycle each
  typedef struct packed {
    logic       startTimer;   // Timer-start instruction
    logic       skipRequest;  // Skip-on-request instruction
    logic       readCount;    // Read-count instruction, held while executing
    logic       modeWrite;    // Port output to mode register
    logic [3:0] modeNibble;   // Accumulator nibble written
    logic       haltEnter;    // Halt instruction
  } tecp_cmd_s;

  // Whole block state
  typedef struct packed {
    logic [1:0]         srcSel;
    logic [PRESC_W-1:0] presc;
    logic               evSync1;
    logic               evSync2;
    logic               evLast;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] readData;
    logic               reqFlag;
    logic               overflow;
    logic               halted;
    logic               cpuClk;
    logic               pendPulse;
  } tecp_state_s;
endpackage

// >>> rtl/tecp_timer.sv
// Timer/event counter with prescalers, source select and halt clock gate
`timescale 1ns/10ps
`default_nettype none
module tecp_timer
  #(
    parameter int CountWidth = tecp_pkg::COUNT_W, // Count register width
    parameter int PrescWidth = tecp_pkg::PRESC_W  // Free prescaler width
  )
  (
    input  wire logic            core_clk,    // System clock, 50 MHz
    input  wire logic            sys_rst,     // Synchronous reset, active high
    input  wire tecp_pkg::tecp_cmd_s cmd,     // Instruction strobes from CPU
    input  wire logic            eventPin,    // External event pin, async
    output logic [7:0]           countRead,   // Count captured by read-count
    output logic                 reqFlag,     // Timer request flag
    output logic                 overflowEvt, // One-cycle overflow pulse
    output logic                 cpuClk,      // CPU clock, system clock / 2
    output logic                 halted       // Halt mode active
  );
  import tecp_pkg::*;

  // ============================================================
  // Elaboration checks
  // The state struct is sized by the package and the output port is fixed at 8 bits, so the
  // widths may not be moved away from it, and every tap must exist.
  if (CountWidth != COUNT_W)
  begin : g_bad_count
    $error("count width must match the package count width");
  end
  if (PrescWidth != PRESC_W || TAP_DIV256 >= PrescWidth)
  begin : g_bad_presc
    $error("prescaler width must match the package and hold every tap");
  end

  // ============================================================
  // Prescaler tap decode
  // A tap gives one pulse when its bit falls; the three dividers share it
  function automatic logic tapFall
    (
      input logic [PRESC_W-1:0] prevVal, // Prescaler before the step
      input logic [PRESC_W-1:0] nextVal, // Prescaler after the step
      input int                 tap      // Tap bit position
    );
    tapFall = prevVal[tap] & ~nextVal[tap];
  endfunction

  tecp_state_s s_q;
  tecp_state_s s_d;
  logic        pulse;
  logic        takePulse;

  // ============================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    // Two-stage synchroniser and edge history
    s_d.evSync1 = eventPin;
    s_d.evSync2 = s_q.evSync1;
    s_d.evLast  = s_q.evSync2;
    // Prescaler runs from the system clock, halted or not
    s_d.presc = s_q.presc + PRESC_ONE;
    // Source select mux
    unique case (s_q.srcSel)
      SRC_DIV256: pulse = tapFall(s_q.presc, s_d.presc, TAP_DIV256);
      SRC_EVENT:  pulse = s_q.evSync2 & ~s_q.evLast;
      SRC_DIV32:  pulse = tapFall(s_q.presc, s_d.presc, TAP_DIV32);
      SRC_DIV4:   pulse = tapFall(s_q.presc, s_d.presc, TAP_DIV4);
    endcase
    // Pulses arriving during a read are held, then applied
    takePulse = 1'b0;
    if (cmd.readCount)
    begin
      s_d.pendPulse = s_q.pendPulse | pulse;
      s_d.readData  = s_q.count;
    end
    else
    begin
      takePulse     = pulse | s_q.pendPulse;
      s_d.pendPulse = 1'b0;
    end
    s_d.overflow = 1'b0;
    if (takePulse)
    begin
      s_d.count = s_q.count + COUNT_ONE;
      if (s_q.count == COUNT_MAX)
        s_d.overflow = 1'b1;
    end
    // Request flag: set wins over a clear in the same cycle
    if (cmd.skipRequest || cmd.startTimer)
      s_d.reqFlag = 1'b0;
    if (s_d.overflow)
      s_d.reqFlag = 1'b1;
    if (cmd.startTimer)
    begin
      s_d.count     = COUNT_ZERO;
      s_d.pendPulse = 1'b0;
    end
    if (cmd.modeWrite)
      s_d.srcSel = {cmd.modeNibble[SEL_HIGH_BIT], cmd.modeNibble[SEL_LOW_BIT]};
    // Halt gates the divider input only
    if (cmd.haltEnter && !s_q.reqFlag)
      s_d.halted = 1'b1;
    if (s_d.reqFlag)
      s_d.halted = 1'b0;
    s_d.cpuClk = s_q.halted ? s_q.cpuClk : ~s_q.cpuClk;
  end

  // ============================================================
  // State register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_q        <= '0;
      s_q.srcSel <= SRC_RESET;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops
  assign countRead   = s_q.readData;
  assign reqFlag     = s_q.reqFlag;
  assign overflowEvt = s_q.overflow;
  assign cpuClk      = s_q.cpuClk;
  assign halted      = s_q.halted;

  // ============================================================
  // Checks
  property p_ovf_sets_flag;
    @(posedge core_clk) disable iff (sys_rst)
      overflowEvt |-> reqFlag;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag) else $error("flag not set");

  property p_ovf_wraps;
    @(posedge core_clk) disable iff (sys_rst)
      overflowEvt |-> s_q.count == COUNT_ZERO || $past(cmd.startTimer);
  endproperty
  a_ovf_wraps: assert property (p_ovf_wraps) else $error("no wrap");

  property p_start_clears;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.startTimer && !s_d.overflow |=> s_q.count == COUNT_ZERO && !reqFlag;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start failed");

  property p_skip_clears;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.skipRequest && !s_d.overflow |=> !reqFlag;
  endproperty
  a_skip_clears: assert property (p_skip_clears) else $error("skip failed");

  property p_read_holds;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.readCount && !cmd.startTimer |=> $stable(s_q.count);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("count moved");

  property p_read_value;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.readCount |=> countRead == $past(s_q.count);
  endproperty
  a_read_value: assert property (p_read_value) else $error("bad read");

  property p_step_one;
    @(posedge core_clk) disable iff (sys_rst)
      !cmd.startTimer && !overflowEvt ##1 !overflowEvt && !$past(cmd.startTimer)
        |-> s_q.count == $past(s_q.count) || s_q.count == $past(s_q.count) + COUNT_ONE;
  endproperty
  a_step_one: assert property (p_step_one) else $error("bad step");

  property p_halt_clk;
    @(posedge core_clk) disable iff (sys_rst)
      halted ##1 halted |-> $stable(cpuClk);
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("cpu clock ran");

  property p_run_clk;
    @(posedge core_clk) disable iff (sys_rst)
      !halted ##1 1'b1 |-> cpuClk != $past(cpuClk);
  endproperty
  a_run_clk: assert property (p_run_clk) else $error("cpu clock stuck");

  property p_wake;
    @(posedge core_clk) disable iff (sys_rst)
      overflowEvt |-> !halted;
  endproperty
  a_wake: assert property (p_wake) else $error("halt not ended");

  // A cycle with no instruction that could hold, clear or retarget the count
  sequence s_quiet;
    !cmd.readCount && !cmd.startTimer && !cmd.modeWrite;
  endsequence

  // Four quiet cycles on the fastest source always move the count
  property p_div4;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.srcSel == SRC_DIV4 && !s_q.pendPulse ##0 s_quiet ##1 s_quiet [*3]
        |=> $past(s_q.count, 4) != s_q.count;
  endproperty
  a_div4: assert property (p_div4) else $error("div4 stalled");

  // ============================================================
  // Reset, source load and prescaler checks
  // Reset clears every output and falls back to the slowest source
  property p_reset_clears;
    @(posedge core_clk)
      sys_rst |=> countRead == COUNT_ZERO && !reqFlag && !halted && !overflowEvt
        && s_q.srcSel == SRC_RESET;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

  // The mode write lands in the source field on the next cycle
  property p_mode_load;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.modeWrite
        |=> s_q.srcSel == $past({cmd.modeNibble[SEL_HIGH_BIT], cmd.modeNibble[SEL_LOW_BIT]});
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("source not loaded");

  // The prescaler never stops, halted or not
  property p_presc_free;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> s_q.presc == $past(s_q.presc) + PRESC_ONE;
  endproperty
  a_presc_free: assert property (p_presc_free) else $error("prescaler stopped");

  // ============================================================
  // Event pin checks
  // The second stage only ever copies the first
  property p_sync_chain;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> s_q.evSync2 == $past(s_q.evSync1);
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("sync chain broken");

  // A synchronised rising edge on the event source steps the count once
  property p_event_step;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.srcSel == SRC_EVENT && s_q.evSync2 && !s_q.evLast && !cmd.readCount
        && !cmd.startTimer |=> s_q.count == $past(s_q.count) + COUNT_ONE;
  endproperty
  a_event_step: assert property (p_event_step) else $error("event not counted");

  // ============================================================
  // Read hold-off checks
  // A pulse that meets a read is kept rather than lost
  property p_pend_kept;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.readCount && pulse && !cmd.startTimer |=> s_q.pendPulse;
  endproperty
  a_pend_kept: assert property (p_pend_kept) else $error("held pulse lost");

  // A kept pulse is applied once the read is over
  property p_pend_applied;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.pendPulse && !cmd.readCount && !cmd.startTimer
        |=> s_q.count == $past(s_q.count) + COUNT_ONE;
  endproperty
  a_pend_applied: assert property (p_pend_applied) else $error("held pulse dropped");

  // ============================================================
  // Request flag and halt checks
  // The flag stands until an instruction clears it
  property p_flag_holds;
    @(posedge core_clk) disable iff (sys_rst)
      reqFlag && !cmd.skipRequest && !cmd.startTimer |=> reqFlag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

  // The overflow pulse lasts a single cycle
  property p_ovf_single;
    @(posedge core_clk) disable iff (sys_rst)
      overflowEvt |=> !overflowEvt;
  endproperty
  a_ovf_single: assert property (p_ovf_single) else $error("overflow too long");

  // Halt is refused while a request is pending
  property p_halt_refused;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.haltEnter && reqFlag |=> !halted;
  endproperty
  a_halt_refused: assert property (p_halt_refused) else $error("halt entered");

  // Halt is taken when no request is pending or arriving
  property p_halt_enter;
    @(posedge core_clk) disable iff (sys_rst)
      cmd.haltEnter && !reqFlag && !s_d.reqFlag |=> halted;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");

  // A request arriving during halt wakes the CPU clock
  property p_halt_wake;
    @(posedge core_clk) disable iff (sys_rst)
      halted && s_d.reqFlag |=> !halted;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt kept");

  // Limitation: a read held for many cycles keeps only one pulse, so a
  // source faster than the read length loses counts; the CPU keeps reads
  // to one instruction, which the fastest source cannot outrun.
endmodule // tecp_timer
`default_nettype wire

// >>> tb/tecp_cpu_model.sv
// CPU-side model issuing timer instructions to the counter
`timescale 1ns/10ps
`default_nettype none
module tecp_cpu_model
  (
    input  wire logic               core_clk, // System clock
    output var  tecp_pkg::tecp_cmd_s cmd      // Instruction strobes
  );
  import tecp_pkg::*;
  // ============================================================
  // Issue
  // One instruction for one cycle, launched and dropped at falling edges
  task automatic issue(input tecp_cmd_s c);
    @(negedge core_clk) cmd = c;
    @(negedge core_clk) cmd = '0;
  endtask
  // Mode load by port output, lowest nibble bit kept zero
  task automatic setMode(input logic [1:0] sel);
    tecp_cmd_s c;
    c = '0;
    c.modeWrite = 1'b1;
    c.modeNibble = {1'b0, sel, 1'b0};
    issue(c);
  endtask
  initial cmd = '0;
endmodule // tecp_cpu_model
`default_nettype wire

// >>> tb/test_timer_event_counter_prescale.sv
// Self-checking bench for the timer/event counter
`timescale 1ns/10ps
`default_nettype none
module test_timer_event_counter_prescale;
  import tecp_pkg::*;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       eventPin = 1'b0;
  tecp_cmd_s  cmd;
  logic [7:0] countRead, v0, v1;
  logic       reqFlag, overflowEvt, cpuClk, halted, c0;
  int         fail_count = 0;
  int         checked = 0;
  int         n;
  logic [1:0] sels[3] = '{SRC_DIV4, SRC_DIV32, SRC_DIV256};
  int         divs[3] = '{4, 32, 256};
  // ============================================================
  // Clock and instances
  always #10 core_clk = ~core_clk;
  tecp_cpu_model cpu (.core_clk(core_clk), .cmd(cmd));
  tecp_timer uut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd), .eventPin(eventPin),
    .countRead(countRead), .reqFlag(reqFlag), .overflowEvt(overflowEvt), .cpuClk(cpuClk),
    .halted(halted));
  // ============================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read-count; captured value settles by the dropping edge
  task automatic rd(output logic [7:0] v);
    tecp_cmd_s c;
    c = '0;
    c.readCount = 1'b1;
    cpu.issue(c);
    v = countRead;
  endtask
  // 0 start, 1 skip-on-request, 2 halt
  task automatic op(input int k);
    tecp_cmd_s c;
    c = '0;
    c.startTimer = (k == 0);
    c.skipRequest = (k == 1);
    c.haltEnter = (k == 2);
    cpu.issue(c);
  endtask
  // Cycles to the next overflow pulse, bounded
  task automatic waitOvf;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
      if (n > 1100)
      begin
        fail_count++;
        close_out();
      end
    end while (overflowEvt !== 1'b1);
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    check(countRead, 8'h00);
    check({reqFlag, halted}, 2'h0);
    c0 = cpuClk;
    @(negedge core_clk);
    check(cpuClk, {7'h00, ~c0});
    $display("reset test done");
    // Ten prescaled periods give ten counts
    for (int i = 0; i < 3; i++)
    begin
      cpu.setMode(sels[i]);
      op(0);
      rd(v0);
      repeat (divs[i] * 10 - 2) @(negedge core_clk);
      rd(v1);
      check(v1 - v0, 8'h0A);
    end
    $display("divider test done");
    cpu.setMode(SRC_DIV4);
    op(0);
    waitOvf();
    check(reqFlag, 1'b1);
    waitOvf();
    check(8'(n - 1000), 8'h18);
    op(1);
    check(reqFlag, 1'b0);
    op(2);
    check(halted, 1'b1);
    c0 = cpuClk;
    @(negedge core_clk);
    check(cpuClk, c0);
    waitOvf();
    check(halted, 1'b0);
    op(0);
    check(reqFlag, 1'b0);
    $display("overflow and halt test done");
    // Event pin counted while halted
    cpu.setMode(SRC_EVENT);
    op(0);
    op(2);
    repeat (5)
    begin
      @(negedge core_clk) eventPin = 1'b1;
      repeat (3) @(negedge core_clk);
      eventPin = 1'b0;
      repeat (3) @(negedge core_clk);
    end
    check(halted, 1'b1);
    rd(v0);
    check(v0, 8'h05);
    $display("event test done");
    close_out();
  end
endmodule // test_timer_event_counter_prescale
`default_nettype wire
